// ==== rtl/adc_control_power_modes.sv ====
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// ============================================================
// Converter control with APB registers and power-mode handling
module adc_control_power_modes (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] analog_sample,
  output logic [3:0] channel_sel,
  output logic [1:0] reference_sel,
  output logic converter_enable,
  output logic bandgap_on,
  output logic sample_strobe,
  output logic irq,
  output logic irq_high_priority
);
  // ==========================================================
  // Registers
  logic [7:0] chan_ctrl_q; // Channel control
  logic [7:0] timing_ctrl_q; // Timing control
  logic [7:0] pin_low_q; // Pin config low
  logic [7:0] pin_high_q; // Pin config high
  logic [7:0] trig_q; // Trigger select
  logic [7:0] status_q; // Sticky flags
  logic [7:0] enable_q; // Interrupt mask
  logic [7:0] prio_q; // Priority
  logic [1:0] pmode_q; // Power mode: sleep, idle
  logic [11:0] result_q; // Last conversion
  logic go_q; // Conversion running
  adc_ctrl_pkg::conv_state_t state_q;
  logic [4:0] hold_q; // Start-delay counter
  logic [4:0] step_q; // Conversion step counter
  logic tick;
  logic done_evt;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic go_write;
  logic sleep_blocked;

  // Address decode shared by read and write
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      adc_ctrl_pkg::ADDR_CHANNEL_CONTROL, adc_ctrl_pkg::ADDR_TIMING_CONTROL,
      adc_ctrl_pkg::ADDR_PIN_CONFIG_LOW, adc_ctrl_pkg::ADDR_PIN_CONFIG_HIGH,
      adc_ctrl_pkg::ADDR_RESULT_HIGH, adc_ctrl_pkg::ADDR_RESULT_LOW,
      adc_ctrl_pkg::ADDR_TRIGGER_SELECT, adc_ctrl_pkg::ADDR_IRQ_STATUS,
      adc_ctrl_pkg::ADDR_IRQ_ENABLE, adc_ctrl_pkg::ADDR_IRQ_PRIORITY,
      adc_ctrl_pkg::ADDR_POWER_MODE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign addr_ok = is_mapped(paddr);
  assign wr_acc = psel && penable && pwrite && addr_ok;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok;
  assign go_write = wr_acc && (paddr == adc_ctrl_pkg::ADDR_CHANNEL_CONTROL)
                    && pwdata[adc_ctrl_pkg::BIT_GO];
  // Sleep without RC clock cannot convert, so start is refused
  assign sleep_blocked = pmode_q[adc_ctrl_pkg::BIT_SLEEP]
      && (timing_ctrl_q[adc_ctrl_pkg::CLK_LSB +: 3] != adc_ctrl_pkg::CLK_RC);

  // Channel control: go bit lives in go_q, not here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ctrl_q <= adc_ctrl_pkg::RST_ZERO;
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_CHANNEL_CONTROL) begin
      chan_ctrl_q <= pwdata[7:0];
    end
  end

  // Timing fields; ignored mid-conversion to keep timing stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_ctrl_q <= adc_ctrl_pkg::RST_ZERO;
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_TIMING_CONTROL && !go_q) begin
      timing_ctrl_q <= pwdata[7:0];
    end
  end

  // Analog pin configuration, all pins digital after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_low_q <= adc_ctrl_pkg::RST_PIN_CONFIG;
      pin_high_q <= adc_ctrl_pkg::RST_PIN_CONFIG & adc_ctrl_pkg::MASK_PIN_HIGH;
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_PIN_CONFIG_LOW) begin
      pin_low_q <= pwdata[7:0];
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_PIN_CONFIG_HIGH) begin
      pin_high_q <= pwdata[7:0] & adc_ctrl_pkg::MASK_PIN_HIGH;
    end
  end

  // Trigger select, upper six bits unimplemented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= adc_ctrl_pkg::RST_ZERO;
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_TRIGGER_SELECT) begin
      trig_q <= pwdata[7:0] & adc_ctrl_pkg::MASK_TRIGGER;
    end
  end

  // Enable, priority and power-mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= adc_ctrl_pkg::RST_ZERO;
      prio_q <= adc_ctrl_pkg::RST_ZERO;
      pmode_q <= 2'b00;
    end else if (wr_acc) begin
      if (paddr == adc_ctrl_pkg::ADDR_IRQ_ENABLE) begin
        enable_q <= pwdata[7:0] & adc_ctrl_pkg::MASK_DONE;
      end
      if (paddr == adc_ctrl_pkg::ADDR_IRQ_PRIORITY) begin
        prio_q <= pwdata[7:0] & adc_ctrl_pkg::MASK_DONE;
      end
      if (paddr == adc_ctrl_pkg::ADDR_POWER_MODE) begin
        pmode_q <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Conversion sequencer
  adc_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_q == adc_ctrl_pkg::ST_CONV),
    .clk_sel(timing_ctrl_q[adc_ctrl_pkg::CLK_LSB +: 3]),
    .tick(tick)
  );

  // Idle mode leaves the sequencer running; only Sleep without the RC clock blocks a start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      hold_q <= 5'h00;
      step_q <= 5'h00;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          if (go_write && !go_q && chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON]
              && !sleep_blocked) begin
            // Zero acquisition: one instruction cycle for sleep entry
            if (timing_ctrl_q[adc_ctrl_pkg::ACQ_LSB +: 3] == adc_ctrl_pkg::ACQ_ZERO) begin
              hold_q <= 5'(adc_ctrl_pkg::TCY_CYCLES);
              state_q <= adc_ctrl_pkg::ST_HOLD;
            end else begin
              state_q <= adc_ctrl_pkg::ST_CONV;
            end
            step_q <= 5'h00;
          end
        end
        adc_ctrl_pkg::ST_HOLD: begin
          if (hold_q <= 5'h01) begin
            state_q <= adc_ctrl_pkg::ST_CONV;
          end
          hold_q <= hold_q - 5'h01;
        end
        adc_ctrl_pkg::ST_CONV: begin
          // Running regardless of idle flag
          if (!chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON]) begin
            state_q <= adc_ctrl_pkg::ST_IDLE;
          end else if (tick) begin
            if (step_q == 5'(adc_ctrl_pkg::CONV_TAD - 1)) begin
              state_q <= adc_ctrl_pkg::ST_DONE;
            end
            step_q <= step_q + 5'h01;
          end
        end
        adc_ctrl_pkg::ST_DONE: begin
          state_q <= adc_ctrl_pkg::ST_IDLE;
        end
        default: begin
          state_q <= adc_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign done_evt = (state_q == adc_ctrl_pkg::ST_DONE);
  assign sample_strobe = done_evt;

  // Go bit: set by start, held while busy, cleared at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= 1'b0;
    end else if (state_q == adc_ctrl_pkg::ST_IDLE) begin
      go_q <= go_write && chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON]
              && !go_q && !sleep_blocked;
    end else if (done_evt) begin
      go_q <= 1'b0;
    end else if (state_q == adc_ctrl_pkg::ST_CONV
                 && !chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON]) begin
      go_q <= 1'b0;
    end
  end

  // Result capture on completion; calibration runs leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 12'h000;
    end else if (done_evt && !timing_ctrl_q[adc_ctrl_pkg::BIT_CALIBRATION]) begin
      result_q <= analog_sample;
    end
  end

  // Sticky done flag; set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= adc_ctrl_pkg::RST_ZERO;
    end else if (done_evt) begin
      status_q[adc_ctrl_pkg::BIT_DONE_FLAG] <= 1'b1;
    end else if (wr_acc && paddr == adc_ctrl_pkg::ADDR_IRQ_STATUS) begin
      status_q <= status_q & ~(pwdata[7:0] & adc_ctrl_pkg::MASK_DONE);
    end
  end

  assign irq = |(status_q & enable_q);
  assign irq_high_priority = |(status_q & enable_q & prio_q);

  // ==========================================================
  // Read mux, registered data; unused bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        adc_ctrl_pkg::ADDR_CHANNEL_CONTROL:
          prdata <= {24'h000000, chan_ctrl_q[7:2], go_q,
                     chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON]};
        adc_ctrl_pkg::ADDR_TIMING_CONTROL: prdata <= {24'h000000, timing_ctrl_q};
        adc_ctrl_pkg::ADDR_PIN_CONFIG_LOW: prdata <= {24'h000000, pin_low_q};
        adc_ctrl_pkg::ADDR_PIN_CONFIG_HIGH: prdata <= {24'h000000, pin_high_q};
        // Right justified: 4 high bits / 8 low; left: 8 high / 4 low
        adc_ctrl_pkg::ADDR_RESULT_HIGH:
          prdata <= timing_ctrl_q[adc_ctrl_pkg::BIT_RESULT_FORMAT]
                    ? {24'h000000, 4'h0, result_q[11:8]}
                    : {24'h000000, result_q[11:4]};
        adc_ctrl_pkg::ADDR_RESULT_LOW:
          prdata <= timing_ctrl_q[adc_ctrl_pkg::BIT_RESULT_FORMAT]
                    ? {24'h000000, result_q[7:0]}
                    : {24'h000000, result_q[3:0], 4'h0};
        adc_ctrl_pkg::ADDR_TRIGGER_SELECT: prdata <= {24'h000000, trig_q};
        adc_ctrl_pkg::ADDR_IRQ_STATUS: prdata <= {24'h000000, status_q};
        adc_ctrl_pkg::ADDR_IRQ_ENABLE: prdata <= {24'h000000, enable_q};
        adc_ctrl_pkg::ADDR_IRQ_PRIORITY: prdata <= {24'h000000, prio_q};
        adc_ctrl_pkg::ADDR_POWER_MODE: prdata <= {30'h00000000, pmode_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Analog front-end drives
  assign channel_sel = chan_ctrl_q[adc_ctrl_pkg::CHS_LSB +: 4];
  assign reference_sel = chan_ctrl_q[7:6];
  assign converter_enable = chan_ctrl_q[adc_ctrl_pkg::BIT_CONVERTER_ON];
  assign bandgap_on = pin_high_q[adc_ctrl_pkg::BIT_BANDGAP];

  // ==========================================================
  // Checks
  // Completion clears go and raises the sticky flag on one edge
  chk_go_clears_done: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt |=> !go_q && status_q[adc_ctrl_pkg::BIT_DONE_FLAG])
    else $error("go not cleared or flag not set at completion");
  // Zero acquisition holds one instruction cycle before converting
  chk_zero_acq_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_IDLE && go_write && !go_q && !sleep_blocked
     && converter_enable
     && timing_ctrl_q[adc_ctrl_pkg::ACQ_LSB +: 3] == adc_ctrl_pkg::ACQ_ZERO)
    |=> state_q == adc_ctrl_pkg::ST_HOLD ##4 state_q == adc_ctrl_pkg::ST_CONV)
    else $error("zero acquisition start not delayed one cycle");
  // An accepted start shows go on the next cycle
  chk_go_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_IDLE && go_write && !go_q && !sleep_blocked
     && converter_enable) |=> go_q)
    else $error("go bit not set by start");
  // Go stays up for the whole conversion
  chk_go_held: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_CONV && converter_enable) |-> go_q)
    else $error("go bit dropped while converting");
  // No start from Sleep without the RC clock
  chk_sleep_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_IDLE && sleep_blocked) |=> !go_q)
    else $error("conversion started in sleep without rc clock");
  // Idle entry must not drop a running conversion
  chk_idle_runs: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_CONV && pmode_q[adc_ctrl_pkg::BIT_IDLE]
     && converter_enable) |=> state_q != adc_ctrl_pkg::ST_IDLE)
    else $error("idle mode aborted conversion");
  // The flag only falls on a write-one clear
  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (status_q[adc_ctrl_pkg::BIT_DONE_FLAG] && !(wr_acc && paddr == adc_ctrl_pkg::ADDR_IRQ_STATUS))
    |=> status_q[adc_ctrl_pkg::BIT_DONE_FLAG])
    else $error("done flag lost without clear");
  // Interrupt level follows flag and enable
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (status_q[adc_ctrl_pkg::BIT_DONE_FLAG] && enable_q[adc_ctrl_pkg::BIT_DONE_FLAG]))
    else $error("interrupt output mismatch");
  // High-priority line only when the priority bit is set as well
  chk_irq_priority: assert property (@(posedge pclk) disable iff (!presetn)
    irq_high_priority == (irq && prio_q[adc_ctrl_pkg::BIT_DONE_FLAG]))
    else $error("high priority interrupt mismatch");
  // Unimplemented bits hold zero
  chk_trig_zero: assert property (@(posedge pclk) disable iff (!presetn)
    trig_q[7:2] == 6'h00 && pin_high_q[6:5] == 2'b00)
    else $error("unimplemented bits set");
  // Completion strobe lasts a single cycle
  chk_strobe_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    sample_strobe |=> !sample_strobe)
    else $error("completion strobe longer than one cycle");
  // Normal completion captures the core sample
  chk_result_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (done_evt && !timing_ctrl_q[adc_ctrl_pkg::BIT_CALIBRATION])
    |=> result_q == $past(analog_sample))
    else $error("result not captured at completion");
  // Calibration completion leaves the result alone
  chk_cal_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (done_evt && timing_ctrl_q[adc_ctrl_pkg::BIT_CALIBRATION])
    |=> $stable(result_q))
    else $error("calibration run changed the result");
  // Timing writes are dropped while a conversion is busy
  chk_timing_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (go_q && wr_acc && paddr == adc_ctrl_pkg::ADDR_TIMING_CONTROL)
    |=> $stable(timing_ctrl_q))
    else $error("timing changed during conversion");
  // Clearing converter_on aborts without a completion
  chk_abort_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == adc_ctrl_pkg::ST_CONV && !converter_enable)
    |=> state_q == adc_ctrl_pkg::ST_IDLE && !go_q)
    else $error("abort did not return to idle");
  // Upper bus bits read zero on every register
  chk_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite) |=> prdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  // Unmapped reads return zero in the access phase
  chk_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !addr_ok) |-> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");
endmodule : adc_control_power_modes

// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIMING_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_PIN_CONFIG_LOW = 8'h08;
  localparam logic [7:0] ADDR_PIN_CONFIG_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h14;
  localparam logic [7:0] ADDR_TRIGGER_SELECT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'h24;
  localparam logic [7:0] ADDR_POWER_MODE = 8'h28;
  // ==========================================================
  // Field positions
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_GO = 1;
  localparam int CHS_LSB = 2;
  localparam int BIT_RESULT_FORMAT = 7;
  localparam int BIT_CALIBRATION = 6;
  localparam int ACQ_LSB = 3;
  localparam int CLK_LSB = 0;
  localparam int BIT_DONE_FLAG = 6;
  localparam int BIT_BANDGAP = 7;
  localparam int BIT_SLEEP = 0;
  localparam int BIT_IDLE = 1;
  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PIN_CONFIG = 8'hFF;
  localparam logic [7:0] MASK_PIN_HIGH = 8'h9F;
  localparam logic [7:0] MASK_TRIGGER = 8'h03;
  localparam logic [7:0] MASK_DONE = 8'h40;
  localparam logic [2:0] ACQ_ZERO = 3'h0;
  localparam logic [2:0] CLK_RC = 3'h7;
  // ==========================================================
  // Timing: conversion clock and instruction cycle
  localparam int CLK_MHZ = 200;
  localparam int TCY_NS = 20;
  localparam int TCY_CYCLES = (TCY_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_TAD = 12;
  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_CONV = 2'b10,
    ST_DONE = 2'b11
  } conv_state_t;
endpackage : adc_ctrl_pkg

// ==== rtl/adc_tick_gen.sv ====
`timescale 1ns/1ps
// ============================================================
// Conversion clock divider: one-cycle tick per conversion step
module adc_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  logic [7:0] cnt_q;
  logic [7:0] limit;

  // Divide by 2^(sel+1); RC select treated as slowest divisor
  assign limit = 8'((9'h002 << clk_sel) - 9'h001);

  // Counter restarts whenever no conversion runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (!run || cnt_q >= limit) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick = run && (cnt_q >= limit);
endmodule : adc_tick_gen

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Bus, core and status signals
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sample_strobe, irq, irq_high_priority;
  logic converter_enable, bandgap_on;
  logic [11:0] analog_sample; // Core result seen at completion
  logic [3:0] channel_sel;
  logic [1:0] reference_sel;
  logic [31:0] rd; // Last read data
  logic err; // Last error response
  int fails, n_compared, t1, t0, i;
  localparam logic [7:0] A_CH = adc_ctrl_pkg::ADDR_CHANNEL_CONTROL;
  localparam logic [7:0] A_TM = adc_ctrl_pkg::ADDR_TIMING_CONTROL;
  localparam logic [7:0] A_RH = adc_ctrl_pkg::ADDR_RESULT_HIGH;
  localparam logic [7:0] A_RL = adc_ctrl_pkg::ADDR_RESULT_LOW;
  localparam logic [7:0] A_ST = adc_ctrl_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_PM = adc_ctrl_pkg::ADDR_POWER_MODE;
  // ==========================================================
  // Register table: write flag, address, write data, read back
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [17] = '{
    {1'b0, 8'h00, 8'h00, 8'h00}, {1'b0, 8'h04, 8'h00, 8'h00},
    {1'b0, 8'h08, 8'h00, 8'hFF}, {1'b0, 8'h0C, 8'h00, 8'h9F},
    {1'b0, 8'h10, 8'h00, 8'h00}, {1'b0, 8'h14, 8'h00, 8'h00},
    {1'b0, 8'h18, 8'h00, 8'h00}, {1'b0, 8'h1C, 8'h00, 8'h00},
    {1'b0, 8'h20, 8'h00, 8'h00}, {1'b0, 8'h24, 8'h00, 8'h00},
    {1'b1, 8'h08, 8'h00, 8'h00}, {1'b1, 8'h0C, 8'hFF, 8'h9F},
    {1'b1, 8'h18, 8'hFF, 8'h03}, {1'b1, 8'h04, 8'hA5, 8'hA5},
    {1'b1, 8'h20, 8'hFF, 8'h40}, {1'b1, 8'h24, 8'hFF, 8'h40},
    {1'b1, 8'h00, 8'hFC, 8'hFC}
  };

  adc_control_power_modes i_adc_control_power_modes (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_sample(analog_sample),
    .channel_sel(channel_sel), .reference_sel(reference_sel),
    .converter_enable(converter_enable), .bandgap_on(bandgap_on),
    .sample_strobe(sample_strobe), .irq(irq),
    .irq_high_priority(irq_high_priority)
  );

  // ==========================================================
  // Clock: 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compare one result and count it
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Verdict and end of run
  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // One APB transfer; an idle edge follows so psel is never re-driven at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Count edges until the completion strobe; bounded for the slow RC clock
  task wait_done(output int cyc);
    cyc = 0;
    while (sample_strobe !== 1'b1 && cyc < 4000) begin
      @(posedge pclk);
      cyc++;
    end
    if (sample_strobe !== 1'b1) begin
      fails++;
      close_out();
    end
    @(posedge pclk);
  endtask : wait_done

  // Program timing, power the converter on channel 3, then start it
  task conv(input logic [7:0] tm, output int cyc);
    apb(1'b1, A_TM, {24'h0, tm});
    apb(1'b1, A_CH, 32'h0D);
    apb(1'b1, A_CH, 32'h0F);
    wait_done(cyc);
  endtask : conv

  // Read both result bytes and compare them
  task results(input logic [7:0] hi, input logic [7:0] lo);
    apb(1'b0, A_RH, 32'h0);
    chk("result high", {24'h0, hi}, rd);
    apb(1'b0, A_RL, 32'h0);
    chk("result low", {24'h0, lo}, rd);
  endtask : results

  // Hang guard well beyond the longest sequence
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog_sample = 12'hABC;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values except the power mode, then write and read back the writable registers except status and power mode
    for (i = 0; i < 17; i++) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, {24'h0, rows[i].d});
      apb(1'b0, rows[i].a, 32'h0);
      chk($sformatf("reg %h", rows[i].a), {24'h0, rows[i].e}, rd);
    end
    chk("channel_sel", 32'hF, {28'h0, channel_sel});
    chk("reference_sel", 32'h3, {30'h0, reference_sel});
    chk("bandgap_on", 32'h1, {31'h0, bandgap_on});
    chk("converter_enable", 32'h0, {31'h0, converter_enable});
    $display("Test registers done");
    // Unmapped address gives an error and zero data
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("Test unmapped done");
    // Right-justified conversion with acquisition time one
    conv(8'h88, t1);
    chk("irq", 32'h1, {31'h0, irq});
    chk("irq high", 32'h1, {31'h0, irq_high_priority});
    apb(1'b0, A_CH, 32'h0);
    chk("go cleared", 32'h0D, rd);
    apb(1'b0, A_ST, 32'h0);
    chk("flag sticky", 32'h40, rd);
    results(8'h0A, 8'hBC);
    apb(1'b1, A_ST, 32'h40);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("Test right justified done");
    // Zero acquisition time: start held off one instruction cycle
    analog_sample <= 12'h123;
    conv(8'h00, t0);
    chk("hold delay", t1 + adc_ctrl_pkg::TCY_CYCLES, t0);
    results(8'h12, 8'h30);
    apb(1'b1, A_ST, 32'h40);
    $display("Test left justified done");
    // Sleep with a non-RC clock refuses the start
    apb(1'b1, A_PM, 32'h1);
    apb(1'b1, A_CH, 32'h0F);
    apb(1'b0, A_CH, 32'h0);
    chk("sleep refused", 32'h0D, rd);
    // RC clock in sleep runs; timing is frozen; idle entry mid-run
    analog_sample <= 12'h5A7;
    apb(1'b1, A_TM, 32'h07);
    apb(1'b1, A_CH, 32'h0F);
    apb(1'b0, A_CH, 32'h0);
    chk("sleep go", 32'h0F, rd);
    apb(1'b1, A_TM, 32'h80);
    apb(1'b0, A_TM, 32'h0);
    chk("timing frozen", 32'h07, rd);
    apb(1'b1, A_PM, 32'h2);
    wait_done(t0);
    apb(1'b0, A_ST, 32'h0);
    chk("idle flag", 32'h40, rd);
    results(8'h5A, 8'h70);
    apb(1'b1, A_ST, 32'h40);
    apb(1'b1, A_PM, 32'h0);
    $display("Test power modes done");
    // Calibration conversion leaves the result untouched
    analog_sample <= 12'hFFF;
    conv(8'h48, t0);
    apb(1'b0, A_CH, 32'h0);
    chk("cal go", 32'h0D, rd);
    results(8'h5A, 8'h70);
    apb(1'b1, A_TM, 32'h08);
    $display("Test calibration done");
    // Clearing converter_on mid-run aborts with no flag
    apb(1'b1, A_ST, 32'h40);
    apb(1'b1, A_CH, 32'h0F);
    apb(1'b1, A_CH, 32'h0C);
    repeat (30) @(posedge pclk);
    apb(1'b0, A_ST, 32'h0);
    chk("abort no flag", 32'h00, rd);
    apb(1'b0, A_CH, 32'h0);
    chk("abort go", 32'h0C, rd);
    chk("converter off", 32'h0, {31'h0, converter_enable});
    $display("Test abort done");
    // Reset in mid-run drops the conversion and restores defaults
    apb(1'b1, A_CH, 32'h0D);
    apb(1'b1, A_CH, 32'h0F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset strobe", 32'h0, {31'h0, sample_strobe});
    apb(1'b0, A_CH, 32'h0);
    chk("reset chan", 32'h0, rd);
    apb(1'b0, adc_ctrl_pkg::ADDR_PIN_CONFIG_LOW, 32'h0);
    chk("reset pins", 32'hFF, rd);
    repeat (30) @(posedge pclk);
    apb(1'b0, A_ST, 32'h0);
    chk("reset flag", 32'h0, rd);
    $display("Test mid-run reset done");
    close_out();
  end
endmodule : testbench
